// ===== rtl/timer_event_capture_unit_consts.vh
// Summary of operation
// RULE_01: counter starts at load value, counts up
// RULE_02: overflow past all ones reloads or zeroes
// RULE_03: overflow sets sticky timer interrupt flag
// RULE_04: event input counts pin edges when assigned
// RULE_05: second mode register picks counted edges
// RULE_06: source keeps both-edge spacing two cycles
// RULE_07: capture trigger edge also selectable
// RULE_08: trigger captures count, sets flags, clears counter
// RULE_09: second trigger or overflow sets capture error
// RULE_10: capture flags clear on reset or zero write
// RULE_11: entering capture mode clears the counter
// RULE_12: first mode register: reload, clock, prescaler
// RULE_13: mode change takes effect two instructions later
// RULE_14: software should use internal clock for capture
// RULE_15: second mode register: edge and capture enable
// RULE_16: load and readback split in two digits
// RULE_17: captured value stable across digit reads
// RULE_18: standby bit stops the timer clock
// RULE_19: upper digit write loads whole counter
`ifndef TIMER_EVENT_CAPTURE_UNIT_CONSTS_VH
`define TIMER_EVENT_CAPTURE_UNIT_CONSTS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_EVENT_PIN_FUNCTION_SELECT 6'h0A
`define OFS_MODULE_CLOCK_STANDBY      6'h0D
`define OFS_COUNT_MODE_CLOCK_SELECT   6'h18
`define OFS_EDGE_CAPTURE_SELECT       6'h19
`define OFS_LOAD_READ_LOW_DIGIT       6'h1A
`define OFS_LOAD_READ_HIGH_DIGIT      6'h1B
`define OFS_IRQ_STATUS                6'h20
`define OFS_IRQ_CLEAR                 6'h21
`define OFS_IRQ_ENABLE                6'h22

// ----------------------------------------
// field positions
// ----------------------------------------
`define MODE_RELOAD_BIT    3
`define EDGE_CAPTURE_BIT   2
`define EVENT_PIN_BIT      1
`define STANDBY_TIMER_BIT  2
`define STAT_TIMER_IRQ_BIT 0
`define STAT_CAP_BIT       1
`define STAT_CAP_ERR_BIT   2
`define CLK_SEL_EXTERNAL   3'h7
`define EDGE_FALLING       2'h1
`define EDGE_RISING        2'h2
`define EDGE_BOTH          2'h3

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define RST_NIBBLE        4'h0
`define RST_EDGE_SEL      3'h0
`define RST_STATUS        3'h0
`define MODE_DELAY_CYCLES 2
`define COUNT_ALL_ONES    8'hFF
`define COUNT_ZERO        8'h00

`endif

// ===== rtl/timer_event_capture_unit.v
`timescale 1ns/1ps
`default_nettype none
`include "timer_event_capture_unit_consts.vh"

module timer_event_capture_unit #(
  parameter integer PRESCALE_WIDTH = 11
) (
  // clock and reset
  input  wire       sys_clk,
  input  wire       nrst,
  // register port
  input  wire [5:0] reg_addr,
  input  wire [3:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [3:0] reg_rdata,
  // external event pin
  input  wire       event_trigger_pin,
  // interrupt
  output wire       irq
);

  // ----------------------------------------
  // prescaler tap decode
  // ----------------------------------------
  // one tap per internal clock choice; tap k divides by 2^(k+1) scaled
  function [3:0] tap_of;
    input [2:0] sel;
    begin
      case (sel)
        3'h0:    tap_of = 4'hA;
        3'h1:    tap_of = 4'h8;
        3'h2:    tap_of = 4'h6;
        3'h3:    tap_of = 4'h4;
        3'h4:    tap_of = 4'h2;
        3'h5:    tap_of = 4'h1;
        default: tap_of = 4'h0;
      endcase
    end
  endfunction

  // edge match for the selected edge kind
  function edge_hit;
    input [1:0] sel;
    input       rise;
    input       fall;
    begin
      case (sel)
        `EDGE_FALLING: edge_hit = fall;
        `EDGE_RISING:  edge_hit = rise;
        `EDGE_BOTH:    edge_hit = rise | fall;
        default:       edge_hit = 1'b0;
      endcase
    end
  endfunction

  // ----------------------------------------
  // address match
  // ----------------------------------------
  // one compare shared by every strobe decode below
  function addr_hit;
    input [5:0] addr;
    input [5:0] ofs;
    begin
      addr_hit = addr == ofs;
    end
  endfunction

  // ----------------------------------------
  // readback digit select
  // ----------------------------------------
  // live count or held capture, chosen by the capture enable
  function [3:0] read_digit;
    input       upper;
    input       cap;
    input [7:0] live;
    input [7:0] held;
    begin
      if (cap) begin
        read_digit = upper ? held[7:4] : held[3:0];
      end else begin
        read_digit = upper ? live[7:4] : live[3:0];
      end
    end
  endfunction

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg  [3:0]                pin_func_q;
  reg  [3:0]                standby_q;
  reg  [3:0]                mode_wr_q;
  reg  [3:0]                mode_q;
  reg  [`MODE_DELAY_CYCLES-1:0] mode_pend_q;
  reg  [2:0]                edge_sel_q;
  reg  [3:0]                load_lo_q;
  reg  [3:0]                load_hi_q;
  reg  [7:0]                count_q;
  reg  [7:0]                capture_q;
  reg  [2:0]                status_q;
  reg  [2:0]                enable_q;
  reg  [PRESCALE_WIDTH-1:0] prescale_q;
  reg                       pin_meta_q;
  reg                       pin_sync_q;
  reg                       pin_prev_q;

  reg  [7:0]                count_d;
  wire [2:0]                status_d;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire wr_pin_func = reg_wr && addr_hit(reg_addr, `OFS_EVENT_PIN_FUNCTION_SELECT);
  wire wr_standby  = reg_wr && addr_hit(reg_addr, `OFS_MODULE_CLOCK_STANDBY);
  wire wr_mode     = reg_wr && addr_hit(reg_addr, `OFS_COUNT_MODE_CLOCK_SELECT);
  wire wr_edge     = reg_wr && addr_hit(reg_addr, `OFS_EDGE_CAPTURE_SELECT);
  wire wr_lo       = reg_wr && addr_hit(reg_addr, `OFS_LOAD_READ_LOW_DIGIT);
  wire wr_hi       = reg_wr && addr_hit(reg_addr, `OFS_LOAD_READ_HIGH_DIGIT);
  wire wr_status   = reg_wr && addr_hit(reg_addr, `OFS_IRQ_STATUS);
  wire wr_clear    = reg_wr && addr_hit(reg_addr, `OFS_IRQ_CLEAR);
  wire wr_enable   = reg_wr && addr_hit(reg_addr, `OFS_IRQ_ENABLE);

  // ----------------------------------------
  // timer clock and event edges
  // ----------------------------------------
  wire       running    = !standby_q[`STANDBY_TIMER_BIT];                // RULE_18
  wire       capture_on = edge_sel_q[`EDGE_CAPTURE_BIT];
  wire       pin_on     = pin_func_q[`EVENT_PIN_BIT];                    // RULE_04
  wire       pin_rise   = pin_sync_q & ~pin_prev_q;
  wire       pin_fall   = ~pin_sync_q & pin_prev_q;
  wire       ext_sel    = mode_q[2:0] == `CLK_SEL_EXTERNAL;
  // both-edge mode relies on the source keeping edges two cycles apart
  wire       sel_edge   = running && pin_on &&
                          edge_hit(edge_sel_q[1:0], pin_rise, pin_fall); // RULE_05 RULE_06 RULE_07
  wire [PRESCALE_WIDTH-1:0] prescale_inc = prescale_q + 1'b1;
  wire [3:0] tap        = tap_of(mode_q[2:0]);                           // RULE_12
  wire       pre_tick   = running && !ext_sel &&
                          prescale_inc[tap] && !prescale_q[tap];
  wire       tick       = ext_sel ? (sel_edge && !capture_on) : pre_tick; // RULE_04
  wire       trigger    = capture_on && sel_edge;                         // RULE_07
  wire       overflow   = tick && count_q == `COUNT_ALL_ONES;            // RULE_02
  wire       cap_start  = wr_edge && reg_wdata[`EDGE_CAPTURE_BIT] && !capture_on;

  // ----------------------------------------
  // counter next value
  // ----------------------------------------
  always @* begin
    count_d = count_q;
    if (wr_hi) begin
      count_d = {reg_wdata, load_lo_q};                                  // RULE_19 RULE_01
    end else if (cap_start) begin
      count_d = `COUNT_ZERO;                                             // RULE_11
    end else if (trigger) begin
      count_d = `COUNT_ZERO;                                             // RULE_08
    end else if (overflow) begin
      if (mode_q[`MODE_RELOAD_BIT]) begin
        count_d = {load_hi_q, load_lo_q};                                // RULE_02
      end else begin
        count_d = `COUNT_ZERO;                                           // RULE_02
      end
    end else if (tick) begin
      count_d = count_q + 8'h01;                                         // RULE_01
    end
  end

  // ----------------------------------------
  // status next value
  // ----------------------------------------
  wire [2:0] status_set;
  wire [2:0] status_clr;

  assign status_set[`STAT_TIMER_IRQ_BIT] = overflow || trigger;           // RULE_03 RULE_08
  assign status_set[`STAT_CAP_BIT]       = trigger;                       // RULE_08
  assign status_set[`STAT_CAP_ERR_BIT]   = (trigger && status_q[`STAT_CAP_BIT]) ||
                                           (overflow && capture_on);      // RULE_09
  // zero written to the status place or one written to the clear place
  assign status_clr = ({3{wr_status}} & ~reg_wdata[2:0]) |
                      ({3{wr_clear}} & reg_wdata[2:0]);                   // RULE_10

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_status
      // a hardware set outranks a software clear in the same cycle
      assign status_d[g] = status_set[g] | (status_q[g] & ~status_clr[g]);
    end
  endgenerate

  // ----------------------------------------
  // pin synchroniser
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (!nrst) begin
      // pin idles high; a low reset value would fake a rising edge
      pin_meta_q <= 1'b1;
      pin_sync_q <= 1'b1;
    end else begin
      pin_meta_q <= event_trigger_pin;
      pin_sync_q <= pin_meta_q;
    end
  end

  // ----------------------------------------
  // edge detect history
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (!nrst) begin
      pin_prev_q <= 1'b1;
    end else begin
      pin_prev_q <= pin_sync_q;
    end
  end

  // ----------------------------------------
  // pin function and standby
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (!nrst) begin
      pin_func_q <= `RST_NIBBLE;
    end else if (wr_pin_func) begin
      pin_func_q <= reg_wdata;                                           // RULE_04
    end
  end

  always @(posedge sys_clk) begin
    if (!nrst) begin
      standby_q <= `RST_NIBBLE;                                          // RULE_18
    end else if (wr_standby) begin
      standby_q <= reg_wdata;                                            // RULE_18
    end
  end

  // ----------------------------------------
  // mode register and its delay pipe
  // ----------------------------------------
  // a new mode waits in a short pipe before it steers the counter
  always @(posedge sys_clk) begin
    if (!nrst) begin
      mode_pend_q <= {`MODE_DELAY_CYCLES{1'b0}};
    end else begin
      mode_pend_q <= {mode_pend_q[`MODE_DELAY_CYCLES-2:0], wr_mode};   // RULE_13
    end
  end

  always @(posedge sys_clk) begin
    if (!nrst) begin
      mode_wr_q <= `RST_NIBBLE;
    end else if (wr_mode) begin
      mode_wr_q <= reg_wdata;                                            // RULE_12
    end
  end

  // a counter load before this moves is lost to the old mode
  always @(posedge sys_clk) begin
    if (!nrst) begin
      mode_q <= `RST_NIBBLE;                                             // RULE_12
    end else if (mode_pend_q[`MODE_DELAY_CYCLES-1]) begin
      mode_q <= mode_wr_q;                                               // RULE_13
    end
  end

  // ----------------------------------------
  // edge select, load digits, interrupt enable
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (!nrst) begin
      edge_sel_q <= `RST_EDGE_SEL;
    end else if (wr_edge) begin
      edge_sel_q <= reg_wdata[2:0];                                      // RULE_15
    end
  end

  // the low digit only waits; the high digit write moves both
  always @(posedge sys_clk) begin
    if (!nrst) begin
      load_lo_q <= `RST_NIBBLE;
      load_hi_q <= `RST_NIBBLE;
    end else begin
      if (wr_lo) begin
        load_lo_q <= reg_wdata;                                          // RULE_16
      end
      if (wr_hi) begin
        load_hi_q <= reg_wdata;                                          // RULE_16
      end
    end
  end

  always @(posedge sys_clk) begin
    if (!nrst) begin
      enable_q <= `RST_STATUS;
    end else if (wr_enable) begin
      enable_q <= reg_wdata[2:0];
    end
  end

  // ----------------------------------------
  // counter and status flags
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (!nrst) begin
      count_q  <= `COUNT_ZERO;
      status_q <= `RST_STATUS;
    end else begin
      count_q  <= count_d;
      status_q <= status_d;
    end
  end

  // ----------------------------------------
  // prescaler
  // ----------------------------------------
  // standby freezes the divider, so a restart resumes mid-period
  always @(posedge sys_clk) begin
    if (!nrst) begin
      prescale_q <= {PRESCALE_WIDTH{1'b0}};
    end else if (running) begin
      prescale_q <= prescale_inc;                                        // RULE_18
    end
  end

  // ----------------------------------------
  // capture register
  // ----------------------------------------
  // held until the next trigger so digit reads may come in any order
  always @(posedge sys_clk) begin
    if (!nrst) begin
      capture_q <= `COUNT_ZERO;
    end else if (trigger) begin
      capture_q <= count_q;                                              // RULE_08 RULE_17
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  // write-only registers and unmapped addresses read as zero
  always @(posedge sys_clk) begin
    if (!nrst) begin
      reg_rdata <= `RST_NIBBLE;
    end else if (reg_rd) begin
      case (reg_addr)
        `OFS_LOAD_READ_LOW_DIGIT: begin
          reg_rdata <= read_digit(1'b0, capture_on, count_q, capture_q); // RULE_16 RULE_17
        end
        `OFS_LOAD_READ_HIGH_DIGIT: begin
          reg_rdata <= read_digit(1'b1, capture_on, count_q, capture_q); // RULE_16 RULE_17
        end
        `OFS_IRQ_STATUS: begin
          reg_rdata <= {1'b0, status_q};
        end
        `OFS_IRQ_ENABLE: begin
          reg_rdata <= {1'b0, enable_q};
        end
        default: begin
          reg_rdata <= `RST_NIBBLE;
        end
      endcase
    end else begin
      reg_rdata <= `RST_NIBBLE;
    end
  end

  // ----------------------------------------
  // interrupt output
  // ----------------------------------------
  // one level line; software finds the cause in the status register
  wire [2:0] irq_pending;

  generate
    for (g = 0; g < 3; g = g + 1) begin : g_irq
      assign irq_pending[g] = status_q[g] & enable_q[g];
    end
  endgenerate

  assign irq = |irq_pending;                                             // RULE_03

endmodule
`default_nettype wire

// ===== dv/timer_event_capture_unit_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// port checks
// ----
module tecu_checker #(
  parameter integer PRESCALE_WIDTH = 11
) (
  // clock and reset
  input wire       sys_clk,
  input wire       nrst,
  // register port
  input wire [5:0] reg_addr,
  input wire [3:0] reg_wdata,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [3:0] reg_rdata,
  // pin and interrupt
  input wire       event_trigger_pin,
  input wire       irq
);
  // shadow of the enable register
  logic [2:0] en_q;
  always @(posedge sys_clk)
    if (!nrst)
      en_q <= 3'h0;
    else if (reg_wr && reg_addr == 6'h22)
      en_q <= reg_wdata[2:0];
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  a_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata == 4'h0)
    else $error("read data not zero when idle");
  a_wo_reads_zero: assert property (
    reg_rd && reg_addr inside {6'h0A, 6'h0D, 6'h18, 6'h19, 6'h21, 6'h3F}
    |=> reg_rdata == 4'h0) else $error("write-only place read non-zero");
  a_irq_reset_low: assert property (
    disable iff (1'b0) !nrst |=> !irq) else $error("irq after reset");
  a_irq_needs_en: assert property (irq |-> en_q != 3'h0)
    else $error("irq with nothing enabled");
  a_en_readback: assert property (
    reg_rd && reg_addr == 6'h22 |=> reg_rdata == {1'b0, en_q})
    else $error("enable readback wrong");
  a_irq_off_disable: assert property (
    reg_wr && reg_addr == 6'h22 && reg_wdata[2:0] == 3'h0 |=> !irq)
    else $error("irq stays when disabled");
  a_status_irq_match: assert property (
    reg_rd && reg_addr == 6'h20
    |=> ((reg_rdata[2:0] & en_q) != 3'h0) == $past(irq))
    else $error("status and irq disagree");
  a_irq_sticky: assert property (irq && !reg_wr |=> irq)
    else $error("irq dropped with no write");
endmodule
bind timer_event_capture_unit tecu_checker #(.PRESCALE_WIDTH(PRESCALE_WIDTH)) i_chk (
  .sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .event_trigger_pin(event_trigger_pin), .irq(irq));
`default_nettype wire

// ===== dv/event_source_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// event source on the trigger pin
// ----
module event_source_model (
  // clock
  input  wire  sys_clk,
  // pin, idles high like a pulled-up input
  output logic event_trigger_pin
);
  initial event_trigger_pin = 1'b1;
  task automatic pulse(input int n, input int gap);
    repeat (n) begin
      @(posedge sys_clk);
      event_trigger_pin <= 1'b0;
      repeat (gap) @(posedge sys_clk);
      event_trigger_pin <= 1'b1;
      repeat (gap) @(posedge sys_clk);
    end
  endtask
endmodule
`default_nettype wire

// ===== dv/timer_event_capture_unit_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module timer_event_capture_unit_bench;
  logic       sys_clk, nrst, reg_wr, reg_rd;
  logic [5:0] reg_addr;
  logic [3:0] reg_wdata, d, e;
  logic [7:0] v;
  wire  [3:0] reg_rdata;
  wire        pin, irq;
  int         num_errors, checked, i;
  logic [3:0] pf [4] = '{4'h2, 4'h2, 4'h2, 4'h0};
  logic [1:0] es [4] = '{2'h1, 2'h2, 2'h3, 2'h3};
  logic [7:0] ex [4] = '{8'h04, 8'h04, 8'h08, 8'h00};
  logic [5:0] ra [6] = '{6'h0A, 6'h18, 6'h19, 6'h20, 6'h22, 6'h3F};
  timer_event_capture_unit #(.PRESCALE_WIDTH(11)) i_dut (
    .sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .event_trigger_pin(pin), .irq(irq));
  event_source_model i_src (.sys_clk(sys_clk), .event_trigger_pin(pin));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // ----
  // bus tasks
  // ----
  task automatic wr(input logic [5:0] a, input logic [3:0] x);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= x;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [5:0] a, output logic [3:0] x);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1 x = reg_rdata;
  endtask
  // low digit first: the high write moves both into the counter
  task automatic ld(input logic [7:0] x);
    wr(6'h1A, x[3:0]);
    wr(6'h1B, x[7:4]);
  endtask
  task automatic rc(output logic [7:0] x);
    logic [3:0] lo, hi;
    rd(6'h1A, lo);
    rd(6'h1B, hi);
    x = {hi, lo};
  endtask
  task automatic wirq;
    for (int k = 0; k < 100 && irq !== 1'b1; k++) @(posedge sys_clk);
    #1;
  endtask
  task automatic final_report;
    if (num_errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #200us;
    num_errors++;
    final_report;
  end
  // ----
  // tests
  // ----
  initial begin
    nrst = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 4'h0;
    repeat (6) @(posedge sys_clk);
    nrst <= 1'b1;
    foreach (ra[j]) begin
      rd(ra[j], d);
      `CHK("reset read", 4'h0, d)
    end
    wr(6'h0D, 4'h4);
    wr(6'h18, 4'hE);
    repeat (3) @(posedge sys_clk);
    ld(8'hA5);
    rc(v);
    `CHK("held count", 8'hA5, v)
    wr(6'h22, 4'h1);
    ld(8'hFE);
    wr(6'h0D, 4'h0);
    wirq;
    `CHK("overflow irq", 1'b1, irq)
    wr(6'h0D, 4'h4);
    rc(v);
    `CHK("reload high", 4'hF, v[7:4])
    `CHK("irq held", 1'b1, irq)
    wr(6'h22, 4'h0);
    `CHK("irq masked", 1'b0, irq)
    wr(6'h22, 4'h1);
    `CHK("irq unmasked", 1'b1, irq)
    wr(6'h21, 4'h1);
    `CHK("irq cleared", 1'b0, irq)
    wr(6'h18, 4'h6);
    repeat (3) @(posedge sys_clk);
    ld(8'hFE);
    wr(6'h0D, 4'h0);
    wirq;
    wr(6'h0D, 4'h4);
    rc(v);
    `CHK("free high", 4'h0, v[7:4])
    ld(8'h30);
    wr(6'h0D, 4'h0);
    repeat (20) @(posedge sys_clk);
    wr(6'h0D, 4'h4);
    rc(v);
    `CHK("count up", 1'b1, v > 8'h34 && v < 8'h40)
    wr(6'h18, 4'h7);
    wr(6'h0D, 4'h0);
    for (i = 0; i < 4; i++) begin
      wr(6'h0A, pf[i]);
      wr(6'h19, {2'b00, es[i]});
      // let a pin-function switch settle before loading
      repeat (5) @(posedge sys_clk);
      ld(8'h00);
      i_src.pulse(4, 3);
      repeat (4) @(posedge sys_clk);
      rc(v);
      `CHK("event count", ex[i], v)
    end
    wr(6'h18, 4'h6);
    wr(6'h0D, 4'h4);
    wr(6'h0A, 4'h2);
    ld(8'h80);
    wr(6'h19, 4'h5);
    wr(6'h21, 4'h7);
    wr(6'h22, 4'h7);
    wr(6'h0D, 4'h0);
    repeat (20) @(posedge sys_clk);
    i_src.pulse(1, 3);
    repeat (4) @(posedge sys_clk);
    rd(6'h20, d);
    `CHK("capture status", 4'h3, d)
    rd(6'h1B, e);
    rd(6'h1A, d);
    repeat (9) @(posedge sys_clk);
    rc(v);
    `CHK("capture stable", {e, d}, v)
    `CHK("capture value", 1'b1, v > 8'h08 && v < 8'h14)
    i_src.pulse(1, 3);
    repeat (4) @(posedge sys_clk);
    rd(6'h20, d);
    `CHK("capture error", 4'h7, d)
    wr(6'h20, 4'h0);
    rd(6'h20, d);
    `CHK("flags zeroed", 4'h0, d)
    wr(6'h20, 4'h7);
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (6) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(6'h20, d);
    `CHK("status after reset", 4'h0, d)
    `CHK("irq after reset", 1'b0, irq)
    final_report;
  end
endmodule
`default_nettype wire
